/* File: verilog/cpi_map.svh */
// Purpose: Port map, field positions and reset values
// Assumes: 16-bit I/O addresses, 8-bit data
// Notes:   Definitions only
`ifndef CPI_MAP_SVH
`define CPI_MAP_SVH
`define CPI_ALIAS_MASK  16'hFFE3
`define CPI_M_EVEN      16'h0020
`define CPI_M_ODD       16'h0021
`define CPI_S_EVEN      16'h00A0
`define CPI_S_ODD       16'h00A1
`define CPI_M_TRIG      16'h04D0
`define CPI_S_TRIG      16'h04D1
`define CPI_OW1_RST     8'h00
`define CPI_OW2_RST     8'h20
`define CPI_OW3_RST     8'h22
`define CPI_IW4_RST     8'h01
`define CPI_TRIG_RST    8'h00
`define CPI_RD_NONE     8'h00
`define CPI_PRIO_INIT   3'h7
`define CPI_SADR_INIT   3'h7
`define CPI_SEL_BIT     4
`define CPI_SINGLE_OR_CASCADE_BIT    1
`define CPI_IW4_BIT     0
`define CPI_OW3_BIT     3
`define CPI_RR_BIT      1
`define CPI_RIS_BIT     0
`define CPI_ESMM_BIT    6
`define CPI_SMM_BIT     5
`define CPI_BASE_F      7:3
`define CPI_LVL_F       2:0
`define CPI_CMD_F       7:5
`define CPI_MID_F       4:2
`define CPI_SETPRIO     3'h6
`define CPI_CASC_IRQ    3'h2
`define CPI_CASC_BIT    2
`define CPI_BYTE_F      7:0
`define CPI_HI_F        15:8
`endif

/* File: verilog/cpi_pkg.sv */
// Purpose: Types of the cascaded controller port block
// Assumes: Used with cpi_map.svh
// Notes:   Types only
package cpi_pkg;

  typedef enum logic [1:0] {st_ready, st_wait2, st_wait3, st_wait4} cpi_init_t;

  typedef enum logic [2:0] {
    dec_none, dec_m_even, dec_m_odd, dec_s_even, dec_s_odd, dec_m_trig, dec_s_trig
  } cpi_dec_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        wr;
    logic        rd;
  } cpi_io_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cpi_io_rsp_t;

  typedef struct packed {
    logic       interrupt_ack_strobe;
    logic [2:0] m_level;
    logic [2:0] s_level;
  } cpi_ack_t;

  typedef struct packed {
    logic       valid;
    logic       from_slave;
    logic [7:0] vec;
  } cpi_vec_t;

  typedef struct packed {
    cpi_init_t  st;
    logic       single;
    logic       fourth;
    logic [4:0] base;
    logic [7:0] init_word_three;
    logic [7:0] init_word_four;
    logic [7:0] op_word_one;
    logic [7:0] op_word_two;
    logic [7:0] op_word_three;
    logic [2:0] low_prio;
    logic [2:0] slv_addr;
  } cpi_ctrl_t;

endpackage

/* File: verilog/cpi_ctrl.sv */
// Purpose: One controller: init sequence and operation words
// Assumes: Write strobes already decoded, one cycle each
// Notes:   Starts ready with documented defaults
`timescale 1ns/1ps
`default_nettype none
`include "cpi_map.svh"

module cpi_ctrl (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             wr_even_i,
  input  wire logic             wr_odd_i,
  input  wire logic [7:0]       wdata_i,
  output cpi_pkg::cpi_ctrl_t    view_o
);
  import cpi_pkg::*;

  cpi_ctrl_t s;
  cpi_ctrl_t next_s;
  logic      iw1_wr;

  assign iw1_wr = wr_even_i && wdata_i[`CPI_SEL_BIT];
  assign view_o = s;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    if (iw1_wr) begin
      next_s.st = st_wait2;
      next_s.single = wdata_i[`CPI_SINGLE_OR_CASCADE_BIT];
      next_s.fourth = wdata_i[`CPI_IW4_BIT];
      next_s.op_word_one = `CPI_OW1_RST;
      next_s.low_prio = `CPI_PRIO_INIT;
      next_s.slv_addr = `CPI_SADR_INIT;
      next_s.op_word_three[`CPI_SMM_BIT] = 1'b0;
      next_s.op_word_three[`CPI_RR_BIT] = 1'b1;
      next_s.op_word_three[`CPI_RIS_BIT] = 1'b0;
      // Trigger and interval bits not kept
    end else if (wr_odd_i) begin
      unique case (s.st)
        st_wait2: begin
          next_s.base = wdata_i[`CPI_BASE_F];
          if (!s.single) begin
            next_s.st = st_wait3;
          end else if (s.fourth) begin
            next_s.st = st_wait4;
          end else begin
            next_s.st = st_ready;
          end
        end
        st_wait3: begin
          next_s.init_word_three = wdata_i;
          next_s.st = s.fourth ? st_wait4 : st_ready;
        end
        st_wait4: begin
          next_s.init_word_four = wdata_i;
          next_s.st = st_ready;
        end
        st_ready: begin
          next_s.op_word_one = wdata_i;
        end
      endcase
    end else if (wr_even_i && s.st == st_ready) begin
      if (wdata_i[`CPI_OW3_BIT]) begin
        next_s.op_word_three[`CPI_MID_F] = wdata_i[`CPI_MID_F];
        next_s.op_word_three[`CPI_ESMM_BIT] = wdata_i[`CPI_ESMM_BIT];
        if (wdata_i[`CPI_ESMM_BIT]) begin
          next_s.op_word_three[`CPI_SMM_BIT] = wdata_i[`CPI_SMM_BIT];
        end
        if (wdata_i[`CPI_RR_BIT]) begin
          next_s.op_word_three[`CPI_RIS_BIT] = wdata_i[`CPI_RIS_BIT];
        end
      end else begin
        next_s.op_word_two = wdata_i;
        if (wdata_i[`CPI_CMD_F] == `CPI_SETPRIO) begin
          next_s.low_prio = wdata_i[`CPI_LVL_F];
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s <= '{st: st_ready, single: 1'b0, fourth: 1'b1, base: 5'h00,
             init_word_three: 8'h00, init_word_four: `CPI_IW4_RST,
             op_word_one: `CPI_OW1_RST, op_word_two: `CPI_OW2_RST,
             op_word_three: `CPI_OW3_RST, low_prio: `CPI_PRIO_INIT,
             slv_addr: `CPI_SADR_INIT};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_iw1_init;
    iw1_wr |=> s.st == st_wait2 && s.op_word_one == 8'h00 && s.low_prio == 3'h7 && s.op_word_three[1:0] == 2'b10;
  endproperty
  a_iw1_init: assert property (p_iw1_init) else $error("init word one effects missing");

  property p_base_kept;
    s.st == st_wait2 && wr_odd_i && !iw1_wr |=> s.base == $past(wdata_i[7:3]) ##1 s.base == $past(s.base);
  endproperty
  a_base_kept: assert property (p_base_kept) else $error("vector base not kept");

endmodule
`default_nettype wire

/* File: verilog/cpi_port.sv */
// Purpose: I/O port front end of a cascaded controller pair
// Assumes: Host I/O strobes and acknowledges on mclk_i
// Notes:   Priority resolution lives outside this block
`timescale 1ns/1ps
`default_nettype none
`include "cpi_map.svh"

// Behaviour
// - Master ports decode at 20h/21h, slave ports at A0h/A1h.
// - Even and odd ports alias every 4h, slave up to BCh.
// - Even port reaches op words two and three with their defaults.
// - Odd port reaches op word one, reset 00h; word four resets 01h.
// - Trigger select registers at 4D0h and 4D1h, read-write, reset 00h.
// - Init word one clears mask, sets priority and slave address, status.
// - After init word one, word two, then three if cascaded and four if bit 0 was set, follow in order.
// - Even port write with bit 4 set starts initialization.
// - Level trigger bit of init word one is ignored.
// - Call address interval bit is ignored; software writes zero.
// - Init word two bits 7:3 become the vector upper bits.
// - Acknowledge fills level into low bits, vector on second cycle.
// - Level code 000 to 111 maps inputs in ascending order.
// - Slave matches broadcast code with its id and supplies vector.
module cpi_port (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  input  wire cpi_pkg::cpi_io_req_t io_req_i,
  output cpi_pkg::cpi_io_rsp_t    io_rsp_o,
  input  wire cpi_pkg::cpi_ack_t  ack_i,
  input  wire logic [15:0]        pending_request_reg_i,
  input  wire logic [15:0]        in_service_i,
  output cpi_pkg::cpi_vec_t       vec_o,
  output cpi_pkg::cpi_ctrl_t      m_view_o,
  output cpi_pkg::cpi_ctrl_t      s_view_o,
  output logic [15:0]             trigger_type_select_o
);
  import cpi_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic cpi_dec_t cpi_decode(input logic [15:0] a);
    logic [15:0] m;
    m = a & `CPI_ALIAS_MASK;
    if (m == `CPI_M_EVEN) begin
      cpi_decode = dec_m_even;
    end else if (m == `CPI_M_ODD) begin
      cpi_decode = dec_m_odd;
    end else if (m == `CPI_S_EVEN) begin
      cpi_decode = dec_s_even;
    end else if (m == `CPI_S_ODD) begin
      cpi_decode = dec_s_odd;
    end else if (a == `CPI_M_TRIG) begin
      cpi_decode = dec_m_trig;
    end else if (a == `CPI_S_TRIG) begin
      cpi_decode = dec_s_trig;
    end else begin
      cpi_decode = dec_none;
    end
  endfunction

  typedef struct packed {
    cpi_io_rsp_t rsp;
    cpi_vec_t    vec;
    logic        phase;
    logic        casc;
    logic [2:0]  code;
    logic [7:0]  m_trig;
    logic [7:0]  s_trig;
  } cpi_top_t;

  cpi_top_t  t;
  cpi_top_t  next_t;
  cpi_dec_t  wdec;
  cpi_dec_t  rdec;
  cpi_ctrl_t mv;
  cpi_ctrl_t sv;
  logic      wr_m_even;
  logic      wr_m_odd;
  logic      wr_s_even;
  logic      wr_s_odd;
  logic      ack_first;
  logic      ack_second;
  logic      slv_match;

  assign wdec      = cpi_decode(io_req_i.addr);
  assign rdec      = cpi_decode(io_req_i.addr);
  assign wr_m_even = io_req_i.wr && wdec == dec_m_even;
  assign wr_m_odd  = io_req_i.wr && wdec == dec_m_odd;
  assign wr_s_even = io_req_i.wr && wdec == dec_s_even;
  assign wr_s_odd  = io_req_i.wr && wdec == dec_s_odd;

  // ----------------------------------------
  // Controllers
  // ----------------------------------------
  cpi_ctrl u_master (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .wr_even_i (wr_m_even),
    .wr_odd_i  (wr_m_odd),
    .wdata_i   (io_req_i.data),
    .view_o    (mv)
  );

  cpi_ctrl u_slave (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .wr_even_i (wr_s_even),
    .wr_odd_i  (wr_s_odd),
    .wdata_i   (io_req_i.data),
    .view_o    (sv)
  );

  // ----------------------------------------
  // Acknowledge sequence
  // ----------------------------------------
  assign ack_first  = ack_i.interrupt_ack_strobe && !t.phase;
  assign ack_second = ack_i.interrupt_ack_strobe && t.phase;
  assign slv_match  = t.casc && sv.init_word_three[`CPI_LVL_F] == t.code;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_t = t;
    next_t.rsp.valid = 1'b0;
    next_t.vec.valid = 1'b0;
    if (io_req_i.wr) begin
      unique case (wdec)
        dec_m_trig: next_t.m_trig = io_req_i.data;
        dec_s_trig: next_t.s_trig = io_req_i.data;
        default: next_t.m_trig = t.m_trig;
      endcase
    end
    if (io_req_i.rd) begin
      next_t.rsp.valid = 1'b1;
      unique case (rdec)
        dec_m_even: begin
          next_t.rsp.data = mv.op_word_three[`CPI_RIS_BIT] ?
                            in_service_i[`CPI_BYTE_F] : pending_request_reg_i[`CPI_BYTE_F];
        end
        dec_s_even: begin
          next_t.rsp.data = sv.op_word_three[`CPI_RIS_BIT] ?
                            in_service_i[`CPI_HI_F] : pending_request_reg_i[`CPI_HI_F];
        end
        dec_m_odd:  next_t.rsp.data = mv.op_word_one;
        dec_s_odd:  next_t.rsp.data = sv.op_word_one;
        dec_m_trig: next_t.rsp.data = t.m_trig;
        dec_s_trig: next_t.rsp.data = t.s_trig;
        dec_none:   next_t.rsp.data = `CPI_RD_NONE;
      endcase
    end
    if (ack_first) begin
      next_t.phase = 1'b1;
      next_t.code  = ack_i.m_level;
      next_t.casc  = mv.init_word_three[`CPI_CASC_BIT] && ack_i.m_level == `CPI_CASC_IRQ;
    end else if (ack_second) begin
      next_t.phase = 1'b0;
      next_t.vec.valid = 1'b1;
      next_t.vec.from_slave = slv_match;
      if (slv_match) begin
        next_t.vec.vec = {sv.base, ack_i.s_level};
      end else begin
        next_t.vec.vec = {mv.base, t.code};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      t <= '{rsp: '{valid: 1'b0, data: `CPI_RD_NONE},
             vec: '{valid: 1'b0, from_slave: 1'b0, vec: 8'h00},
             phase: 1'b0, casc: 1'b0, code: 3'h0,
             m_trig: `CPI_TRIG_RST, s_trig: `CPI_TRIG_RST};
    end else begin
      t <= next_t;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign io_rsp_o              = t.rsp;
  assign vec_o                 = t.vec;
  assign m_view_o              = mv;
  assign s_view_o              = sv;
  assign trigger_type_select_o = {t.s_trig, t.m_trig};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_m_decode;
    io_req_i.wr && io_req_i.addr == 16'h0020 && io_req_i.data[4] |=> mv.st == st_wait2;
  endproperty
  a_m_decode: assert property (p_m_decode) else $error("master even port not decoded");

  property p_s_alias;
    io_req_i.wr && io_req_i.addr == 16'h00BC && io_req_i.data[4] |=> sv.st == st_wait2 && mv.st == $past(mv.st);
  endproperty
  a_s_alias: assert property (p_s_alias) else $error("slave alias not decoded");

  property p_irr_read;
    io_req_i.rd && io_req_i.addr == 16'h0020 && !mv.op_word_three[0]
      |=> io_rsp_o.valid && io_rsp_o.data == $past(pending_request_reg_i[7:0]);
  endproperty
  a_irr_read: assert property (p_irr_read) else $error("status read wrong");

  property p_mask_rw;
    mv.st == st_ready && wr_m_odd
      ##1 !wr_m_odd && !wr_m_even
      ##1 io_req_i.rd && io_req_i.addr == 16'h0021 |=> io_rsp_o.data == $past(io_req_i.data, 3);
  endproperty
  a_mask_rw: assert property (p_mask_rw) else $error("op word one not read back");

  property p_trig;
    io_req_i.wr && io_req_i.addr == 16'h04D1 |=> trigger_type_select_o[15:8] == $past(io_req_i.data);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger select not written");

  property p_defaults;
    $fell(rst_i) |-> mv.op_word_one == 8'h00 && mv.init_word_four == 8'h01 && trigger_type_select_o == 16'h0000;
  endproperty
  a_defaults: assert property (@(posedge mclk_i) p_defaults) else $error("reset values wrong");

  property p_sequence;
    mv.st == st_wait2 && wr_m_odd && !mv.single |=> mv.st == st_wait3;
  endproperty
  a_sequence: assert property (p_sequence) else $error("init order broken");

  property p_master_vec;
    ack_second && !slv_match |=> vec_o.valid && vec_o.vec == {$past(mv.base), $past(t.code)};
  endproperty
  a_master_vec: assert property (p_master_vec) else $error("master vector wrong");

  property p_slave_vec;
    ack_second && slv_match |=> vec_o.from_slave && vec_o.vec[2:0] == $past(ack_i.s_level);
  endproperty
  a_slave_vec: assert property (p_slave_vec) else $error("slave did not supply vector");

  property p_vec_once;
    vec_o.valid |=> !vec_o.valid;
  endproperty
  a_vec_once: assert property (p_vec_once) else $error("vector valid held");

  property p_m_trig;
    io_req_i.wr && io_req_i.addr == 16'h04D0 |=> trigger_type_select_o[7:0] == $past(io_req_i.data);
  endproperty
  a_m_trig: assert property (p_m_trig) else $error("master trigger select not written");

  property p_none_read;
    io_req_i.rd && rdec == dec_none |=> io_rsp_o.valid && io_rsp_o.data == 8'h00;
  endproperty
  a_none_read: assert property (p_none_read) else $error("unmapped read not zero");

  property p_rd_answer;
    io_req_i.rd |=> io_rsp_o.valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

  property p_level_trigger_bit_ignored;
    wr_m_even && io_req_i.data[4] && io_req_i.data[3] |=> mv.st == st_wait2 && mv.op_word_one == 8'h00;
  endproperty
  a_level_trigger_bit_ignored: assert property (p_level_trigger_bit_ignored) else $error("level trigger bit not ignored");

  property p_prio_cmd;
    wr_m_even && mv.st == st_ready && io_req_i.data[7:3] == 5'h18 |=> mv.low_prio == $past(io_req_i.data[2:0]);
  endproperty
  a_prio_cmd: assert property (p_prio_cmd) else $error("priority command not routed");

  property p_isr_read;
    io_req_i.rd && rdec == dec_m_even && mv.op_word_three[0] |=> io_rsp_o.data == $past(in_service_i[7:0]);
  endproperty
  a_isr_read: assert property (p_isr_read) else $error("in-service read wrong");

  property p_s_irr_read;
    io_req_i.rd && rdec == dec_s_even && !sv.op_word_three[0]
      |=> io_rsp_o.data == $past(pending_request_reg_i[15:8]);
  endproperty
  a_s_irr_read: assert property (p_s_irr_read) else $error("slave status read wrong");

  property p_s_base;
    wr_s_odd && sv.st == st_wait2 |=> s_view_o.base == $past(io_req_i.data[7:3]);
  endproperty
  a_s_base: assert property (p_s_base) else $error("slave vector base not kept");

  property p_code_latch;
    ack_first |=> t.phase && t.code == $past(ack_i.m_level);
  endproperty
  a_code_latch: assert property (p_code_latch) else $error("broadcast code not latched");

  c_init: cover property (wr_m_even && io_req_i.data[4] ##[1:20] mv.st == st_ready);
  c_slave_ack: cover property (vec_o.valid && vec_o.from_slave);
  c_master_ack: cover property (vec_o.valid && !vec_o.from_slave);
  c_restart: cover property (wr_m_even && io_req_i.data[4] && mv.st != st_ready);
  c_isr_read: cover property (io_req_i.rd && rdec == dec_m_even && mv.op_word_three[0]);

endmodule
`default_nettype wire

/* File: test/cpi_host.sv */
// Purpose: Host processor model issuing port cycles and acknowledges
// Assumes: Requests launched just after rising mclk_i edges
// Notes:   Every answer wait is bounded; released lines show inverted values
`timescale 1ns/1ps
`default_nettype none
module cpi_host (
  input  wire logic                 mclk_i,
  input  wire cpi_pkg::cpi_io_rsp_t io_rsp_i,
  input  wire cpi_pkg::cpi_vec_t    vec_i,
  output cpi_pkg::cpi_io_req_t      io_req_o,
  output cpi_pkg::cpi_ack_t         ack_o
);
  import cpi_pkg::*;
  initial begin
    io_req_o = '0;
    ack_o    = '0;
  end
  // ----
  // Port cycles
  // ----
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    io_req_o <= '{addr: a, data: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    io_req_o <= '{addr: ~a, data: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic wait_on(input logic sel, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 4; i++) begin
      #1;
      if ((sel ? vec_i.valid : io_rsp_i.valid) === 1'b1) begin
        ok = 1'b1;
        break;
      end
      @(posedge mclk_i);
    end
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(posedge mclk_i);
    io_req_o <= '{addr: a, data: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    io_req_o <= '{addr: ~a, data: 8'hFF, wr: 1'b0, rd: 1'b0};
    wait_on(1'b0, ok);
    d = io_rsp_i.data;
  endtask
  // Level codes valid only at their own strobe
  task automatic ack(input logic [2:0] m, input logic [2:0] s, output logic [7:0] v,
                     output logic fs, output logic ok);
    @(posedge mclk_i);
    ack_o <= '{interrupt_ack_strobe: 1'b1, m_level: m, s_level: ~s};
    @(posedge mclk_i);
    ack_o <= '{interrupt_ack_strobe: 1'b1, m_level: ~m, s_level: s};
    @(posedge mclk_i);
    ack_o <= '{interrupt_ack_strobe: 1'b0, m_level: ~m, s_level: ~s};
    wait_on(1'b1, ok);
    v  = vec_i.vec;
    fs = vec_i.from_slave;
  endtask
  // Full init sequence, reserved bits zero
  task automatic init(input logic [15:0] a, input logic [7:0] base, input logic [7:0] w3);
    wr(a, 8'h11);
    wr(a | 16'h0001, base);
    wr(a | 16'h0001, w3);
    wr(a | 16'h0001, 8'h01);
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: Self-checking bench of the cascaded controller port block
// Assumes: Host model drives port and acknowledge cycles
// Notes:   Reset checks, then table rows, hand tests after
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cpi_pkg::*;
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
  } cpi_row_t;
  logic        mclk_i, rst_i, ok, fs;
  logic [7:0]  d;
  logic [15:0] pend, insvc, trig;
  cpi_io_req_t io_req;
  cpi_io_rsp_t io_rsp;
  cpi_ack_t    ack;
  cpi_vec_t    vec;
  cpi_ctrl_t   m_view, s_view;
  int          n_fail, cmp_count;
  localparam cpi_row_t ROWS [22] = '{
    '{1'b1, 16'h0021, 8'h00}, '{1'b1, 16'h04D0, 8'h00}, '{1'b1, 16'h04D1, 8'h00},
    '{1'b0, 16'h04D0, 8'hA5}, '{1'b1, 16'h04D0, 8'hA5}, '{1'b0, 16'h04D1, 8'h5A},
    '{1'b1, 16'h04D1, 8'h5A}, '{1'b0, 16'h0021, 8'hFF}, '{1'b1, 16'h003D, 8'hFF},
    '{1'b1, 16'h0020, 8'hC3}, '{1'b1, 16'h00BC, 8'h5A}, '{1'b1, 16'h0022, 8'h00},
    '{1'b0, 16'h0020, 8'h19}, '{1'b1, 16'h0021, 8'h00}, '{1'b0, 16'h0025, 8'h08},
    '{1'b0, 16'h0029, 8'h04}, '{1'b0, 16'h002D, 8'h01}, '{1'b0, 16'h0031, 8'h3C},
    '{1'b1, 16'h0021, 8'h3C}, '{1'b0, 16'h0020, 8'h0B}, '{1'b1, 16'h0024, 8'h96},
    '{1'b1, 16'h00B1, 8'h00}
  };
  cpi_port u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .io_req_i(io_req), .io_rsp_o(io_rsp), .ack_i(ack),
    .pending_request_reg_i(pend), .in_service_i(insvc), .vec_o(vec), .m_view_o(m_view),
    .s_view_o(s_view), .trigger_type_select_o(trig)
  );
  cpi_host u_host (
    .mclk_i(mclk_i), .io_rsp_i(io_rsp), .vec_i(vec), .io_req_o(io_req), .ack_o(ack)
  );
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // ----
  // Checking and closing
  // ----
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic got(input logic k);
    chk("answer", 8'(k), 8'h01);
    if (k !== 1'b1) begin
      stop_test();
    end
  endtask
  task automatic do_reset();
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    chk("ow2", m_view.op_word_two, 8'h20);
    chk("ow3", s_view.op_word_three, 8'h22);
    chk("iw4", m_view.init_word_four, 8'h01);
    chk("ow1", s_view.op_word_one, 8'h00);
    chk("trig", trig[15:8] | trig[7:0], 8'h00);
    $display("reset test done");
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    rst_i     = 1'b1;
    pend      = 16'h5AC3;
    insvc     = 16'h6996;
    n_fail    = 0;
    cmp_count = 0;
    do_reset();
    u_host.init(16'h00BC, 8'h70, 8'h02);
    foreach (ROWS[i]) begin
      if (ROWS[i].rd) begin
        u_host.rd(ROWS[i].addr, d, ok);
        got(ok);
        chk($sformatf("row%0d", i), d, ROWS[i].data);
      end else begin
        u_host.wr(ROWS[i].addr, ROWS[i].data);
      end
    end
    chk("trig_lo", trig[7:0], 8'hA5);
    chk("sbase", 8'(s_view.base), 8'h0E);
    $display("table test done");
    for (int m = 0; m < 8; m++) begin
      u_host.ack(3'(m), 3'(7 - m), d, fs, ok);
      got(ok);
      chk("vec", d, (m == 2) ? {5'h0E, 3'(7 - m)} : {5'h01, 3'(m)});
      chk("from_slave", 8'(fs), 8'(m == 2));
    end
    $display("acknowledge test done");
    u_host.wr(16'h0020, 8'hC3);
    #1;
    chk("prio_set", 8'(m_view.low_prio), 8'h03);
    u_host.wr(16'h0020, 8'h11);
    u_host.wr(16'h0021, 8'h40);
    u_host.wr(16'h0020, 8'h11);
    #1;
    chk("prio", 8'(m_view.low_prio), 8'h07);
    chk("sadr", 8'(m_view.slv_addr), 8'h07);
    u_host.init(16'h0020, 8'h48, 8'h04);
    #1;
    chk("st", 8'(m_view.st), 8'(st_ready));
    chk("mbase", 8'(m_view.base), 8'h09);
    u_host.rd(16'h0020, d, ok);
    got(ok);
    chk("status", d, 8'hC3);
    u_host.ack(3'h5, 3'h1, d, fs, ok);
    got(ok);
    chk("vec_new", d, 8'h4D);
    $display("restart test done");
    do_reset();
    u_host.rd(16'h04D0, d, ok);
    got(ok);
    chk("trig_rd", d, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
